// File: src/scmc_top.sv
// System clock select, fast oscillator control and halt-mode sequencing.
// Assumes oscillator tick pulses synchronous to sys_clk and an APB master.
`timescale 1ns/1ps
`include "scmc_consts.svh"
module scmc_top (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic haltReq,
	input wire logic wakeReq,
	input wire logic fastTick,
	input wire logic slowTick,
	input wire logic wdtTimeout,
	output logic cpuRun,
	output logic fastOscOn,
	output logic fastClkValid,
	output logic [3:0] fastFreqMhz,
	output logic slowOscOn,
	output logic subClkOn,
	output logic sysClkOn,
	output logic sysTick,
	output logic wdtClear,
	output logic powerDown,
	output logic wdtExpired
);
	import scmc_pkg::*;

	scmc_state_t state_r;
	scmc_state_t state_nxt;
	scmc_sel_t sysClkSel_r;
	logic fastKeepOnHalt_r;
	logic slowKeepOnHalt_r;
	logic [1:0] fastOscFreqSel_r;
	logic [1:0] appliedFreq_r;
	logic fastOscEnable_r;
	logic fastOscStable_r;
	logic settling_r;
	logic [9:0] settleCnt_r;
	logic prevFastOn_r;
	logic pdf_r;
	logic expired_r;
	logic divTick;

	// APB decode
	wire setup = psel && !penable;
	wire wrAcc = psel && penable && pwrite;
	wire hitSel = (paddr == `SCMC_ADDR_CLKSEL);
	wire hitFast = (paddr == `SCMC_ADDR_FASTCTRL);
	wire hitStat = (paddr == `SCMC_ADDR_STATUS);
	wire mapped = hitSel || hitFast || hitStat;
	wire wrSel = wrAcc && hitSel;
	wire wrFast = wrAcc && hitFast;
	wire wrStat = wrAcc && hitStat;

	wire [31:0] rdSel = {24'h0, sysClkSel_r, 3'h0, fastKeepOnHalt_r, slowKeepOnHalt_r};
	wire [31:0] rdFast = {28'h0, fastOscFreqSel_r, fastOscStable_r, fastOscEnable_r};
	wire [31:0] rdStat = {19'h0, state_r, 6'h0, expired_r, pdf_r};
	wire [31:0] rdMux = hitSel ? rdSel : hitFast ? rdFast : hitStat ? rdStat : 32'h0;

	// Every access completes in its first access cycle
	assign pready = psel && penable;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0 : rdMux;
			pslverr <= !mapped;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sysClkSel_r <= 3'(`SCMC_CLKSEL_RST >> `SCMC_SEL_LSB);
			fastKeepOnHalt_r <= 1'b0;
			slowKeepOnHalt_r <= 1'b0;
			fastOscFreqSel_r <= `SCMC_FREQ_RST;
			fastOscEnable_r <= `SCMC_FEN_RST;
		end else begin
			if (wrSel) begin
				sysClkSel_r <= pwdata[`SCMC_SEL_LSB +: 3];
				fastKeepOnHalt_r <= pwdata[`SCMC_KEEP_FAST_BIT];
				slowKeepOnHalt_r <= pwdata[`SCMC_KEEP_SLOW_BIT];
			end
			if (wrFast) begin
				fastOscFreqSel_r <= pwdata[`SCMC_FREQ_LSB +: 2];
				fastOscEnable_r <= pwdata[`SCMC_FEN_BIT];
			end
		end
	end

	// Mode decode
	wire selSub = (sysClkSel_r == `SCMC_SEL_SUB);
	wire running = (state_r == ST_RUN);
	wire haltGo = running && haltReq;

	// Keep bits are looked at only on the halt cycle itself
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (haltReq) begin
					case ({fastKeepOnHalt_r, slowKeepOnHalt_r}) // RQ15
						2'b00: state_nxt = ST_DEEP; // RQ7
						2'b01: state_nxt = ST_SLOW_ONLY; // RQ9
						2'b11: state_nxt = ST_BOTH; // RQ10
						default: state_nxt = ST_FAST_ONLY; // RQ11
					endcase
				end
			end
			ST_DEEP, ST_SLOW_ONLY, ST_BOTH, ST_FAST_ONLY: begin
				if (wakeReq)
					state_nxt = ST_RUN; // RQ15
			end
			default: state_nxt = ST_RUN;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			state_r <= ST_RUN;
		else
			state_r <= state_nxt;
	end

	// Clock enables per mode
	logic fastOnNxt;
	logic subOnNxt;
	logic sysOnNxt;
	always_comb begin
		fastOnNxt = 1'b0;
		subOnNxt = 1'b0;
		sysOnNxt = 1'b0;
		case (state_r)
			ST_RUN: begin
				// Fast mode needs the fast oscillator whatever the enable bit says
				fastOnNxt = !selSub || fastOscEnable_r; // RQ5 RQ6
				subOnNxt = 1'b1; // RQ2 RQ5
				sysOnNxt = 1'b1; // RQ3 RQ4
			end
			ST_DEEP: begin
				fastOnNxt = 1'b0; // RQ7
				subOnNxt = 1'b0;
				sysOnNxt = 1'b0;
			end
			ST_SLOW_ONLY: begin
				fastOnNxt = 1'b0; // RQ9
				subOnNxt = 1'b1;
				sysOnNxt = selSub; // RQ14
			end
			ST_BOTH: begin
				fastOnNxt = 1'b1; // RQ10
				subOnNxt = 1'b1;
				sysOnNxt = 1'b1;
			end
			ST_FAST_ONLY: begin
				fastOnNxt = 1'b1; // RQ11 RQ12
				subOnNxt = 1'b0;
				sysOnNxt = !selSub; // RQ14
			end
			default: begin
				fastOnNxt = 1'b0;
				subOnNxt = 1'b0;
				sysOnNxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cpuRun <= 1'b1;
			fastOscOn <= 1'b1;
			subClkOn <= 1'b1;
			sysClkOn <= 1'b1;
			slowOscOn <= 1'b1;
		end else begin
			cpuRun <= running;
			fastOscOn <= fastOnNxt;
			subClkOn <= subOnNxt;
			sysClkOn <= sysOnNxt;
			slowOscOn <= 1'b1; // RQ8
		end
	end

	// Fast oscillator settling; a new frequency only takes effect once stable
	wire fastStart = fastOscOn && !prevFastOn_r;
	wire freqChange = fastOscOn && (fastOscFreqSel_r != appliedFreq_r) && !settling_r;
	wire settleDone = settling_r && (settleCnt_r == 10'(`SCMC_SETTLE_CYC - 1));

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			prevFastOn_r <= 1'b0;
			settling_r <= 1'b0;
			settleCnt_r <= 10'h0;
			fastOscStable_r <= 1'b0;
			appliedFreq_r <= `SCMC_FREQ_RST;
		end else begin
			prevFastOn_r <= fastOscOn;
			if (!fastOscOn) begin
				settling_r <= 1'b0;
				settleCnt_r <= 10'h0;
				fastOscStable_r <= 1'b0;
			end else if (fastStart || freqChange) begin
				settling_r <= 1'b1; // RQ17
				settleCnt_r <= 10'h0;
				fastOscStable_r <= 1'b0; // RQ17
			end else if (settleDone) begin
				settling_r <= 1'b0;
				fastOscStable_r <= 1'b1; // RQ17
				appliedFreq_r <= fastOscFreqSel_r; // RQ17
			end else if (settling_r) begin
				settleCnt_r <= settleCnt_r + 10'h1;
			end
		end
	end

	// Frequency decode of the applied setting
	wire [3:0] freqDec = (appliedFreq_r == 2'h1) ? `SCMC_FREQ_4MHZ :
		(appliedFreq_r == 2'h2) ? `SCMC_FREQ_8MHZ : `SCMC_FREQ_2MHZ; // RQ16 RQ1

	// Ticks of the fast clock count only while it is running and stable
	wire fastLive = fastOscOn && fastOscStable_r;

	scmc_clk_div #(.W(6)) u_div (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.fastTick(fastTick && fastLive),
		.ratioSel(sysClkSel_r),
		.divTick(divTick)
	);

	wire sysTickNxt = sysClkOn && (selSub ? (slowTick && subClkOn) : divTick); // RQ3 RQ4

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fastClkValid <= 1'b0;
			fastFreqMhz <= `SCMC_FREQ_2MHZ;
			sysTick <= 1'b0;
		end else begin
			fastClkValid <= fastLive; // RQ6 RQ12
			fastFreqMhz <= freqDec;
			sysTick <= sysTickNxt;
		end
	end

	// Status flags; a hardware set wins over a clear in the same cycle
	wire pdfClr = wrStat && pwdata[`SCMC_PDF_BIT];

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pdf_r <= 1'b0;
			expired_r <= 1'b0;
			wdtClear <= 1'b0;
		end else begin
			wdtClear <= haltGo; // RQ18
			if (haltGo)
				pdf_r <= 1'b1; // RQ18
			else if (pdfClr)
				pdf_r <= 1'b0;
			if (wdtTimeout)
				expired_r <= 1'b1;
			else if (haltGo)
				expired_r <= 1'b0; // RQ18
		end
	end

	assign powerDown = pdf_r;
	assign wdtExpired = expired_r;

	AST_DEEP_HALT: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ7
		haltGo && !fastKeepOnHalt_r && !slowKeepOnHalt_r && !wakeReq
		|=> ##1 (!cpuRun && !fastOscOn && !subClkOn && !sysClkOn))
		else $error("deep halt did not stop all clocks");

	AST_SLOW_ALWAYS: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ8
		!cpuRun |-> slowOscOn)
		else $error("slow oscillator stopped while halted");

	AST_SLOW_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ9
		haltGo && !fastKeepOnHalt_r && slowKeepOnHalt_r && !wakeReq
		|=> ##1 (!cpuRun && !fastOscOn && subClkOn && (sysClkOn == selSub)))
		else $error("slow-only idle clocks wrong");

	AST_BOTH_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ10
		haltGo && fastKeepOnHalt_r && slowKeepOnHalt_r && !wakeReq
		|=> ##1 (!cpuRun && fastOscOn && subClkOn))
		else $error("both-running idle clocks wrong");

	AST_FAST_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ11
		haltGo && fastKeepOnHalt_r && !slowKeepOnHalt_r && !wakeReq
		|=> ##1 (!cpuRun && fastOscOn && !subClkOn && (sysClkOn == !selSub)))
		else $error("fast-only idle clocks wrong");

	AST_FAST_RUN: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ5
		$past(running) && running && !selSub && $stable(sysClkSel_r)
		|-> (fastOscOn && subClkOn && sysClkOn))
		else $error("fast mode lost a clock");

	AST_HALT_FLAGS: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ18
		haltGo && !wdtTimeout |=> (pdf_r && !expired_r && wdtClear))
		else $error("halt flags not updated");

	AST_STABLE_RESTART: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ17
		fastStart |=> (!fastOscStable_r && settling_r))
		else $error("stable flag not cleared on start");

	AST_FREQ_DECODE: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ16
		$stable(appliedFreq_r) && $past(appliedFreq_r) == 2'h2 |-> fastFreqMhz == 4'h8)
		else $error("8 MHz code decoded wrongly");

	AST_HOLD_MODE: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ15
		!running && !wakeReq |=> $stable(state_r))
		else $error("halt mode changed without wake");
endmodule : scmc_top

// File: inc/scmc_consts.svh
// Constants for the system clock and power-mode controller.
// Assumes a 40 MHz sys_clk and a 32-bit APB register bus.
// Function
// RQ1: Fast clock from fast RC, three frequencies
// RQ2: Sub clock from slow RC oscillator
// RQ3: Select codes 0-6 run fast divided
// RQ4: Select code 7 runs from sub clock
// RQ5: Fast mode keeps all clocks running
// RQ6: Slow mode fast oscillator follows enable
// RQ7: Halt, both keeps clear, deep halt
// RQ8: Slow oscillator always runs for watchdog
// RQ9: Halt, slow keep only, slow idle
// RQ10: Halt, both keeps set, both idle
// RQ11: Halt, fast keep only, fast idle
// RQ12: Fast idle keeps fast clock for peripherals
// RQ13: Software matches frequency to configuration option
// RQ14: Idle system clock only if source kept
// RQ15: Keep bits sampled at halt, held till wake
// RQ16: Frequency codes 1=4, 2=8, else 2 MHz
// RQ17: Clear stable, settle, then apply frequency
// RQ18: Halt sets power-down, clears expired, watchdog
`ifndef SCMC_CONSTS_SVH
`define SCMC_CONSTS_SVH
`define SCMC_CLK_MHZ 40
`define SCMC_ADDR_CLKSEL 8'h00
`define SCMC_ADDR_FASTCTRL 8'h04
`define SCMC_ADDR_STATUS 8'h08
`define SCMC_SEL_LSB 5
`define SCMC_SEL_SUB 3'h7
`define SCMC_KEEP_FAST_BIT 1
`define SCMC_KEEP_SLOW_BIT 0
`define SCMC_FREQ_LSB 2
`define SCMC_STABLE_BIT 1
`define SCMC_FEN_BIT 0
`define SCMC_CLKSEL_RST 8'h00
`define SCMC_FREQ_RST 2'h0
`define SCMC_FEN_RST 1'b1
`define SCMC_PDF_BIT 0
`define SCMC_EXP_BIT 1
`define SCMC_STATE_LSB 8
`define SCMC_FREQ_2MHZ 4'h2
`define SCMC_FREQ_4MHZ 4'h4
`define SCMC_FREQ_8MHZ 4'h8
`define SCMC_SETTLE_NS 16000
`define SCMC_SETTLE_CYC ((`SCMC_SETTLE_NS * `SCMC_CLK_MHZ + 999) / 1000)
`endif

// File: inc/scmc_pkg.sv
// Types for the system clock and power-mode controller.
// Assumes nothing beyond the constants header.
package scmc_pkg;
	typedef enum logic [4:0] {
		ST_RUN = 5'b00001,
		ST_DEEP = 5'b00010,
		ST_SLOW_ONLY = 5'b00100,
		ST_BOTH = 5'b01000,
		ST_FAST_ONLY = 5'b10000
	} scmc_state_t;
	typedef logic [2:0] scmc_sel_t;
endpackage : scmc_pkg

// File: src/scmc_clk_div.sv
// Divides the fast clock tick stream by 1 to 64.
// Assumes fastTick is a one-cycle pulse per fast clock period.
`timescale 1ns/1ps
`include "scmc_consts.svh"
module scmc_clk_div #(
	parameter int W = 6
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic fastTick,
	input wire scmc_pkg::scmc_sel_t ratioSel,
	output logic divTick
);
	import scmc_pkg::*;
	logic [W-1:0] cnt_r;
	logic [W-1:0] mask;
	wire hit = fastTick && ((cnt_r & mask) == mask);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_mask
			assign mask[i] = (ratioSel > i);
		end
	endgenerate
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= '0;
			divTick <= 1'b0;
		end else begin
			if (fastTick)
				cnt_r <= cnt_r + 1'b1;
			divTick <= hit;
		end
	end
endmodule : scmc_clk_div

// File: verification/scmc_osc_model.sv
// Oscillator model: fast and slow tick streams for the clock controller.
// Assumes ticks are sampled on sys_clk; a stopped oscillator gives no ticks.
`timescale 1ns/1ps
`include "scmc_consts.svh"
module scmc_osc_model #(
	parameter int SLOW_PER = 1250
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic fastOscOn,
	input wire logic [3:0] fastFreqMhz,
	input wire logic slowOscOn,
	output logic fastTick,
	output logic slowTick
);
	int fCnt;
	int sCnt;
	wire [5:0] fastPer = (fastFreqMhz == 4'h0) ? 6'd20 : 6'(`SCMC_CLK_MHZ / fastFreqMhz);
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fCnt <= 0;
			fastTick <= 1'b0;
		end else if (!fastOscOn) begin
			fCnt <= 0;
			fastTick <= 1'b0;
		end else begin
			fastTick <= (fCnt >= fastPer - 1);
			fCnt <= (fCnt >= fastPer - 1) ? 0 : fCnt + 1;
		end
	end
	// Slow tick at 32 kHz against a 40 MHz clock
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sCnt <= 0;
			slowTick <= 1'b0;
		end else if (!slowOscOn) begin
			sCnt <= 0;
			slowTick <= 1'b0;
		end else begin
			slowTick <= (sCnt == SLOW_PER - 1);
			sCnt <= (sCnt == SLOW_PER - 1) ? 0 : sCnt + 1;
		end
	end
endmodule : scmc_osc_model

// File: verification/system_clock_mode_control_tb.sv
// Self-checking bench for the clock controller over APB.
// Assumes zero-wait APB slave and the oscillator model on the tick inputs.
`timescale 1ns/1ps
module system_clock_mode_control_tb;
	logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, g;
	logic pready, pslverr, er, haltReq = 0, wakeReq = 0, wdtTimeout = 0;
	logic fastTick, slowTick, cpuRun, fastOscOn, fastClkValid, slowOscOn;
	logic subClkOn, sysClkOn, sysTick, wdtClear, powerDown, wdtExpired;
	logic [3:0] fastFreqMhz;
	int errors = 0, tests_run = 0, clrCnt = 0;
	logic [1:0] fc [4] = '{1, 0, 3, 2};
	logic [3:0] fm [4] = '{4, 2, 2, 8};
	logic [3:0] pm [4] = '{2, 4, 2, 2};
	logic [4:0] st [4] = '{5'h02, 5'h04, 5'h10, 5'h08};
	logic fo [4] = '{0, 0, 1, 1};
	logic su [4] = '{0, 1, 0, 1};
	logic [2:0] s;
	scmc_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .haltReq(haltReq), .wakeReq(wakeReq), .fastTick(fastTick),
		.slowTick(slowTick), .wdtTimeout(wdtTimeout), .cpuRun(cpuRun), .fastOscOn(fastOscOn),
		.fastClkValid(fastClkValid), .fastFreqMhz(fastFreqMhz), .slowOscOn(slowOscOn),
		.subClkOn(subClkOn), .sysClkOn(sysClkOn), .sysTick(sysTick), .wdtClear(wdtClear),
		.powerDown(powerDown), .wdtExpired(wdtExpired));
	scmc_osc_model osc (.sys_clk(sys_clk), .rst_b(rst_b), .fastOscOn(fastOscOn),
		.fastFreqMhz(fastFreqMhz), .slowOscOn(slowOscOn), .fastTick(fastTick),
		.slowTick(slowTick));
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (wdtClear === 1'b1) clrCnt <= clrCnt + 1;
	task finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	// Request held until pready is seen high at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		// Only the watchdog ends a wait that never sees pready
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	// Which: 0 watchdog time-out, 1 halt, 2 wake
	task pulse(input int w);
		@(posedge sys_clk);
		wdtTimeout <= (w == 0);
		haltReq <= (w == 1);
		wakeReq <= (w == 2);
		@(posedge sys_clk);
		wdtTimeout <= 0;
		haltReq <= 0;
		wakeReq <= 0;
		cyc(3);
	endtask : pulse
	task gap;
		int n;
		n = 0;
		do @(posedge sys_clk); while (sysTick !== 1'b1 && n++ < 3000);
		g = 0;
		do begin
			@(posedge sys_clk);
			g++;
		end while (sysTick !== 1'b1 && g < 3000);
	endtask : gap
	initial begin
		cyc(12);
		rst_b <= 1;
		apb(0, 8'h00, 0);
		check(rd, 32'h0);
		apb(0, 8'h04, 0);
		check(rd, 32'h1);
		apb(0, 8'h08, 0);
		check(rd, 32'h100);
		apb(0, 8'h0c, 0);
		check(er, 1'b1);
		check(rd, 32'h0);
		cyc(660);
		apb(0, 8'h04, 0);
		check(rd, 32'h3);
		check(fastFreqMhz, 4'h2);
		for (int i = 0; i < 4; i++) begin
			apb(1, 8'h04, {28'h0, fc[i], 2'b01});
			apb(0, 8'h04, 0);
			check({rd[1], fastClkValid, fastFreqMhz}, {2'b00, pm[i]});
			cyc(700);
			apb(0, 8'h04, 0);
			check({rd[30:0], fastClkValid}, {27'h0, fc[i], 2'b11, 1'b1});
			check(fastFreqMhz, fm[i]);
		end
		apb(1, 8'h00, 32'he0);
		apb(1, 8'h04, 32'h08);
		cyc(3);
		check({fastOscOn, sysClkOn, subClkOn}, 3'b011);
		apb(1, 8'h00, 32'h00);
		cyc(3);
		check(fastOscOn, 1'b1);
		apb(1, 8'h04, 32'h09);
		cyc(700);
		for (int i = 0; i < 8; i++) begin
			apb(1, 8'h00, 32'(i) << 5);
			gap();
			gap();
			check(g, (i == 7) ? 32'd1250 : 32'd5 << i);
			check({sysClkOn, subClkOn, slowOscOn, fastOscOn}, 4'hf);
		end
		for (int k = 0; k < 4; k++) begin
			for (int j = 0; j < 2; j++) begin
				s = j ? 3'h7 : 3'h0;
				apb(1, 8'h00, {24'h0, s, 3'h0, 2'(k)});
				pulse(0);
				check(wdtExpired, 1'b1);
				pulse(1);
				check({cpuRun, fastOscOn, subClkOn}, {1'b0, fo[k], su[k]});
				check(sysClkOn, (k == 3) || (k == 1 && s == 7) || (k == 2 && s != 7));
				check({slowOscOn, powerDown, wdtExpired}, 3'b110);
				apb(0, 8'h08, 0);
				check(rd[12:8], st[k]);
				pulse(2);
				check(cpuRun, 1'b1);
				apb(1, 8'h08, 32'h1);
				cyc(2);
				check(powerDown, 1'b0);
			end
		end
		check(clrCnt, 8);
		finish_test();
	end
	initial begin
		cyc(60000);
		errors++;
		finish_test();
	end
endmodule : system_clock_mode_control_tb
